// file: logic/cfgl_top.sv
// Configuration loader, slave port and register set paging
// Overview of operation
// - Mode strap high is slave, floating is master load, low is pins, resistor unsupported.
// - In master mode, act as bus master after power-up and fetch setup from EEPROM.
// - Start the EEPROM fetch only when load request is sampled low.
// - Drive load-done low once the EEPROM fetch completes.
// - After the load, stop mastering and answer as a slave.
// - Capture both address straps once at power-up, floating reads as 0.
// - Answer write address 0x30 to 0x36 by strap; read address has bit 0 set.
// - Writes are START, address, register byte, data byte; each byte acknowledged.
// - Every write to register_set_select lands in the select register.
// - Select bit 2 clear routes accesses to the shared set, set to a channel set.
// - Select bits 1:0 pick the channel set.
// - Select bits 3 and 2 both set make writes reach every channel set.
// - In pin mode settings come from four-level pins decoded four ways.
// - Shared register 0x05 bit 4 shows EEPROM load complete.
`timescale 1ns/1ps
`include "cfgl_params.svh"
module cfgl_top
#(
  parameter int NUM_CTRL = 4,
  parameter int LOAD_BYTES = 16
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Four-level strap and control pins, two-bit comparator codes
  input wire logic [1:0] MODE_STRAP_PIN,
  input wire logic [3:0] ADDR_STRAP_PINS,
  input wire logic [2*NUM_CTRL-1:0] CTRL_PINS,
  // Load chain
  input wire logic LOAD_REQUEST_N,
  output logic LOAD_DONE_N,
  // Serial bus, open drain
  input wire logic SMB_SCL_IN,
  output logic SMB_SCL_OUT,
  output logic SMB_SCL_OE_N,
  input wire logic SMB_SDA_IN,
  output logic SMB_SDA_OUT,
  output logic SMB_SDA_OE_N,
  // Mode status and pin settings
  output logic PIN_MODE,
  output logic MODE_INVALID,
  output cfgl_pkg::cfgl_level_type [NUM_CTRL-1:0] CTRL_LEVELS,
  // Channel register sets
  output logic CH_WR_VALID,
  output cfgl_pkg::cfgl_ch_wr_type CH_WR,
  output logic [1:0] CH_RD_SEL,
  output logic [7:0] CH_RD_ADDR,
  input wire logic [7:0] CH_RDATA
);
  localparam int NPINS = NUM_CTRL + 3;
  localparam logic [7:0] QTR_CYC = 8'(`CFGL_QTR_CYC);
  localparam logic [7:0] LAST_BYTE = 8'(LOAD_BYTES + 2);

  logic [2*NPINS-1:0] codes;
  cfgl_pkg::cfgl_level_type lvl [NPINS];
  assign codes = {CTRL_PINS, ADDR_STRAP_PINS, MODE_STRAP_PIN};

  for (genvar i = 0; i < NPINS; i++)
  begin : g_pin
    cfgl_lvl_decode u_dec (.clk(CLK_SYS), .reset(RESET), .code(codes[2*i+1:2*i]), .level_q(lvl[i]));
  end
  for (genvar i = 0; i < NUM_CTRL; i++)
  begin : g_ctrl
    assign CTRL_LEVELS[i] = lvl[i+3];
  end

  // Strap capture; decoders need one edge after release, so capture on the second
  logic [1:0] cap_q, cap_d;
  logic [1:0] adr_q, adr_d;
  cfgl_pkg::cfgl_mode_type mode_q, mode_d;
  logic cap_done;
  assign cap_done = cap_q[1];

  always_comb
  begin
    cap_d = cap_q;
    adr_d = adr_q;
    mode_d = mode_q;
    if (cap_q == 2'h0)
      cap_d = 2'h1;
    else if (cap_q == 2'h1)
    begin
      cap_d = 2'h2;
      adr_d = {lvl[2] == cfgl_pkg::CFGL_LVL_HIGH, lvl[1] == cfgl_pkg::CFGL_LVL_HIGH};
      unique case (lvl[0])
        cfgl_pkg::CFGL_LVL_HIGH: mode_d = cfgl_pkg::CFGL_MODE_SLAVE;
        cfgl_pkg::CFGL_LVL_FLOAT: mode_d = cfgl_pkg::CFGL_MODE_MASTER;
        cfgl_pkg::CFGL_LVL_LOW: mode_d = cfgl_pkg::CFGL_MODE_PIN;
        cfgl_pkg::CFGL_LVL_RES: mode_d = cfgl_pkg::CFGL_MODE_NONE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      cap_q <= 2'h0;
      adr_q <= 2'h0;
      mode_q <= cfgl_pkg::CFGL_MODE_NONE;
    end
    else
    begin
      cap_q <= cap_d;
      adr_q <= adr_d;
      mode_q <= mode_d;
    end
  end

  assign PIN_MODE = cap_done && mode_q == cfgl_pkg::CFGL_MODE_PIN;
  assign MODE_INVALID = cap_done && mode_q == cfgl_pkg::CFGL_MODE_NONE;

  // EEPROM loader: quarter-bit phases, image is register/data pairs
  cfgl_pkg::cfgl_mst_type mst_q, mst_d;
  logic [7:0] qtr_q, qtr_d, byte_q, byte_d, shf_q, shf_d, lda_q, lda_d, ldd_q, ldd_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic mscl_q, mscl_d, msda_q, msda_d, done_q, done_d, err_q, err_d, ldw_q, ldw_d;
  logic tick, rx, last_rx, go;
  assign tick = qtr_q == 8'h00;
  assign rx = byte_q >= 8'h03;
  assign last_rx = byte_q == LAST_BYTE;
  assign go = cap_done && mode_q == cfgl_pkg::CFGL_MODE_MASTER && !LOAD_REQUEST_N && !done_q;

  always_comb
  begin
    mst_d = mst_q;
    qtr_d = tick ? QTR_CYC - 8'h01 : qtr_q - 8'h01;
    ph_d = (mst_q != cfgl_pkg::M_IDLE && tick) ? ph_q + 2'h1 : ph_q;
    bit_d = bit_q;
    byte_d = byte_q;
    shf_d = shf_q;
    mscl_d = mscl_q;
    msda_d = msda_q;
    done_d = done_q;
    err_d = err_q;
    ldw_d = 1'b0;
    lda_d = lda_q;
    ldd_d = ldd_q;
    unique case (mst_q)
      cfgl_pkg::M_IDLE:
        if (go)
        begin
          mst_d = cfgl_pkg::M_START;
          ph_d = 2'h0;
        end
      cfgl_pkg::M_START:
        if (tick)
          unique case (ph_q)
            2'h0:
            begin
              mscl_d = 1'b0;
              msda_d = 1'b0;
            end
            2'h1: msda_d = 1'b1;
            2'h2: mscl_d = 1'b1;
            2'h3:
            begin
              mst_d = cfgl_pkg::M_BIT;
              bit_d = 4'h0;
              shf_d = (byte_q == 8'h00) ? `CFGL_EE_WADDR : `CFGL_EE_RADDR;
            end
          endcase
      cfgl_pkg::M_BIT:
        if (tick)
          unique case (ph_q)
            2'h0:
            begin
              mscl_d = 1'b1;
              msda_d = (bit_q < 4'h8) ? (!rx && !shf_q[7]) : (rx && !last_rx);
            end
            2'h1: mscl_d = 1'b0;
            2'h2:
              if (bit_q < 4'h8)
                shf_d = {shf_q[6:0], rx & SMB_SDA_IN};
              else if (!rx && SMB_SDA_IN)
                err_d = 1'b1;
            2'h3:
            begin
              mscl_d = 1'b1;
              if (bit_q < 4'h8)
                bit_d = bit_q + 4'h1;
              else if (err_q)
                mst_d = cfgl_pkg::M_STOP;
              else
              begin
                byte_d = byte_q + 8'h01;
                bit_d = 4'h0;
                if (rx && byte_q[0])
                  lda_d = shf_q;
                else if (rx)
                begin
                  ldw_d = 1'b1;
                  ldd_d = shf_q;
                end
                if (byte_q == 8'h01)
                  mst_d = cfgl_pkg::M_START;
                else if (last_rx)
                  mst_d = cfgl_pkg::M_STOP;
                else if (byte_q == 8'h00)
                  shf_d = `CFGL_EE_START;
              end
            end
          endcase
      cfgl_pkg::M_STOP:
        if (tick)
          unique case (ph_q)
            2'h0:
            begin
              mscl_d = 1'b1;
              msda_d = 1'b1;
            end
            2'h1: mscl_d = 1'b0;
            2'h2: msda_d = 1'b0;
            2'h3:
            begin
              mst_d = cfgl_pkg::M_DONE;
              done_d = 1'b1;
            end
          endcase
      cfgl_pkg::M_DONE: ;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      mst_q <= cfgl_pkg::M_IDLE;
      qtr_q <= 8'h00;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      byte_q <= 8'h00;
      shf_q <= 8'h00;
      mscl_q <= 1'b0;
      msda_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      ldw_q <= 1'b0;
      lda_q <= 8'h00;
      ldd_q <= 8'h00;
    end
    else
    begin
      mst_q <= mst_d;
      qtr_q <= qtr_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      shf_q <= shf_d;
      mscl_q <= mscl_d;
      msda_q <= msda_d;
      done_q <= done_d;
      err_q <= err_d;
      ldw_q <= ldw_d;
      lda_q <= lda_d;
      ldd_q <= ldd_d;
    end
  end

  assign LOAD_DONE_N = !done_q;

  // Slave port; SCL stretching is not used, so reads must be ready at once
  cfgl_pkg::cfgl_slv_type sl_q, sl_d;
  logic [3:0] sbit_q, sbit_d;
  logic [7:0] sshf_q, sshf_d, ptr_q, ptr_d, sla_q, sla_d, sld_q, sld_d, rd_data;
  logic scl_p_q, sda_p_q, ssda_q, ssda_d, slw_q, slw_d, sl_en, start, stop, rise, fall;
  assign sl_en = cap_done && (mode_q == cfgl_pkg::CFGL_MODE_SLAVE ||
    (mode_q == cfgl_pkg::CFGL_MODE_MASTER && done_q));
  assign start = SMB_SCL_IN && scl_p_q && sda_p_q && !SMB_SDA_IN;
  assign stop = SMB_SCL_IN && scl_p_q && !sda_p_q && SMB_SDA_IN;
  assign rise = SMB_SCL_IN && !scl_p_q;
  assign fall = !SMB_SCL_IN && scl_p_q;

  always_comb
  begin
    sl_d = sl_q;
    sbit_d = sbit_q;
    sshf_d = sshf_q;
    ptr_d = ptr_q;
    ssda_d = ssda_q;
    slw_d = 1'b0;
    sla_d = sla_q;
    sld_d = sld_q;
    if (!sl_en || stop)
    begin
      sl_d = cfgl_pkg::S_IDLE;
      ssda_d = 1'b0;
    end
    else if (start)
    begin
      sl_d = cfgl_pkg::S_ADDR;
      sbit_d = 4'h0;
      ssda_d = 1'b0;
    end
    else
      unique case (sl_q)
        cfgl_pkg::S_IDLE: ;
        cfgl_pkg::S_READ:
          if (rise && sbit_q < 4'h8)
            sbit_d = sbit_q + 4'h1;
          else if (rise && SMB_SDA_IN)
            sl_d = cfgl_pkg::S_IDLE;
          else if (fall && sbit_q == 4'h8)
          begin
            ssda_d = 1'b0;
            sbit_d = 4'h9;
          end
          else if (fall && sbit_q == 4'h9)
          begin
            sshf_d = rd_data;
            ssda_d = !rd_data[7];
            sbit_d = 4'h0;
            ptr_d = ptr_q + 8'h01;
          end
          else if (fall && sbit_q != 4'h0)
          begin
            sshf_d = {sshf_q[6:0], 1'b0};
            ssda_d = !sshf_q[6];
          end
        cfgl_pkg::S_ADDR, cfgl_pkg::S_REG, cfgl_pkg::S_DATA:
          if (rise && sbit_q < 4'h8)
          begin
            sshf_d = {sshf_q[6:0], SMB_SDA_IN};
            sbit_d = sbit_q + 4'h1;
          end
          else if (fall && sbit_q == 4'h8)
          begin
            sbit_d = 4'h9;
            ssda_d = 1'b1;
            if (sl_q == cfgl_pkg::S_ADDR && sshf_q[7:1] != {`CFGL_SMB_BASE, adr_q})
            begin
              ssda_d = 1'b0;
              sl_d = cfgl_pkg::S_IDLE;
            end
            if (sl_q == cfgl_pkg::S_DATA)
            begin
              slw_d = 1'b1;
              sla_d = ptr_q;
              sld_d = sshf_q;
            end
          end
          else if (fall && sbit_q == 4'h9)
          begin
            ssda_d = 1'b0;
            sbit_d = 4'h0;
            if (sl_q == cfgl_pkg::S_ADDR && sshf_q[0])
            begin
              sl_d = cfgl_pkg::S_READ;
              sshf_d = rd_data;
              ssda_d = !rd_data[7];
              ptr_d = ptr_q + 8'h01;
            end
            else if (sl_q == cfgl_pkg::S_ADDR)
              sl_d = cfgl_pkg::S_REG;
            else if (sl_q == cfgl_pkg::S_REG)
            begin
              ptr_d = sshf_q;
              sl_d = cfgl_pkg::S_DATA;
            end
            else
              ptr_d = ptr_q + 8'h01;
          end
      endcase
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      sl_q <= cfgl_pkg::S_IDLE;
      sbit_q <= 4'h0;
      sshf_q <= 8'h00;
      ptr_q <= 8'h00;
      ssda_q <= 1'b0;
      slw_q <= 1'b0;
      sla_q <= 8'h00;
      sld_q <= 8'h00;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      sl_q <= sl_d;
      sbit_q <= sbit_d;
      sshf_q <= sshf_d;
      ptr_q <= ptr_d;
      ssda_q <= ssda_d;
      slw_q <= slw_d;
      sla_q <= sla_d;
      sld_q <= sld_d;
      scl_p_q <= SMB_SCL_IN;
      sda_p_q <= SMB_SDA_IN;
    end
  end

  assign SMB_SCL_OUT = 1'b0;
  assign SMB_SDA_OUT = 1'b0;
  assign SMB_SCL_OE_N = !mscl_q;
  assign SMB_SDA_OE_N = !(msda_q || ssda_q);

  // Register paging; loader and slave never write together since slave waits for done
  logic [7:0] sel_q, sel_d, wr_a, wr_dt;
  logic [3:0] obs_q, obs_d;
  logic wr_v, chv_q, chv_d;
  cfgl_pkg::cfgl_ch_wr_type chw_q, chw_d;
  assign wr_v = ldw_q || slw_q;
  assign wr_a = ldw_q ? lda_q : sla_q;
  assign wr_dt = ldw_q ? ldd_q : sld_q;

  always_comb
  begin
    sel_d = sel_q;
    obs_d = obs_q;
    chv_d = 1'b0;
    chw_d = chw_q;
    if (wr_v && wr_a == `CFGL_REG_SEL)
      sel_d = wr_dt;
    else if (wr_v && !sel_q[`CFGL_SEL_CH])
    begin
      if (wr_a == `CFGL_REG_OBS)
        obs_d = wr_dt[3:0];
    end
    else if (wr_v)
    begin
      chv_d = 1'b1;
      chw_d.addr = wr_a;
      chw_d.data = wr_dt;
      chw_d.mask = sel_q[`CFGL_SEL_ALL] ? `CFGL_ALL_SETS : (`CFGL_ONE_SET << sel_q[1:0]);
    end
  end

  always_comb
  begin
    rd_data = 8'h00;
    if (ptr_q == `CFGL_REG_SEL)
      rd_data = sel_q;
    else if (sel_q[`CFGL_SEL_CH])
      rd_data = CH_RDATA;
    else if (ptr_q == `CFGL_REG_STRAP && obs_q == `CFGL_OBS_KEY)
      rd_data = {2'h0, adr_q, 4'h0};
    else if (ptr_q == `CFGL_REG_STAT)
      rd_data[`CFGL_STAT_DONE] = done_q;
    else if (ptr_q == `CFGL_REG_OBS)
      rd_data = {4'h0, obs_q};
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      sel_q <= `CFGL_SEL_RST;
      obs_q <= `CFGL_OBS_RST;
      chv_q <= 1'b0;
      chw_q <= '0;
    end
    else
    begin
      sel_q <= sel_d;
      obs_q <= obs_d;
      chv_q <= chv_d;
      chw_q <= chw_d;
    end
  end

  assign CH_WR_VALID = chv_q;
  assign CH_WR = chw_q;
  assign CH_RD_SEL = sel_q[1:0];
  assign CH_RD_ADDR = ptr_q;

  mode_pick_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (cap_q == 2'h1 && lvl[0] == cfgl_pkg::CFGL_LVL_FLOAT) |=> mode_q == cfgl_pkg::CFGL_MODE_MASTER)
    else $error("float strap did not pick master mode");
  load_start_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (mst_q == cfgl_pkg::M_IDLE && !go) |=> mst_q == cfgl_pkg::M_IDLE)
    else $error("load left idle without request");
  done_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    done_q |=> done_q && !LOAD_DONE_N)
    else $error("load done dropped");
  mst_quiet_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (mst_q == cfgl_pkg::M_IDLE || mst_q == cfgl_pkg::M_DONE) |-> ##1 SMB_SCL_OE_N)
    else $error("clock driven outside a load");
  slave_off_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (mode_q == cfgl_pkg::CFGL_MODE_MASTER && !done_q) |=> sl_q == cfgl_pkg::S_IDLE)
    else $error("slave active before load end");
  strap_keep_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    cap_done |=> $stable(adr_q) && cap_done)
    else $error("address strap changed");
  addr_ack_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (sl_en && !start && !stop && sl_q == cfgl_pkg::S_ADDR && fall && sbit_q == 4'h8 &&
    sshf_q[7:1] == {`CFGL_SMB_BASE, adr_q}) |=> !SMB_SDA_OE_N)
    else $error("own address not acknowledged");
  sel_write_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_v && wr_a == `CFGL_REG_SEL) |=> sel_q == $past(wr_dt) && !chv_q)
    else $error("select write lost");
  shared_route_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_v && wr_a != `CFGL_REG_SEL && !sel_q[`CFGL_SEL_CH]) |=> !chv_q)
    else $error("shared write reached a channel");
  ch_pick_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_v && wr_a != `CFGL_REG_SEL && sel_q[3:2] == 2'h1) |=>
    chv_q && chw_q.mask == (`CFGL_ONE_SET << $past(sel_q[1:0])))
    else $error("wrong channel set written");
  bcast_all_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_v && wr_a != `CFGL_REG_SEL && sel_q[3:2] == 2'h3) |=> chv_q && chw_q.mask == `CFGL_ALL_SETS)
    else $error("broadcast missed a set");
  stat_done_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (ptr_q == `CFGL_REG_STAT && !sel_q[`CFGL_SEL_CH]) |-> rd_data[`CFGL_STAT_DONE] == done_q)
    else $error("status bit wrong");
endmodule : cfgl_top

// file: logic/cfgl_params.svh
// Constants for the configuration loader and register paging block
`ifndef CFGL_PARAMS_SVH
`define CFGL_PARAMS_SVH
`define CFGL_SYS_KHZ 25000
`define CFGL_EE_KHZ 520
`define CFGL_QTR_CYC (`CFGL_SYS_KHZ / (4 * `CFGL_EE_KHZ))
`define CFGL_EE_WADDR 8'hA0
`define CFGL_EE_RADDR 8'hA1
`define CFGL_EE_START 8'h00
`define CFGL_SMB_BASE 5'h06
`define CFGL_REG_STRAP 8'h00
`define CFGL_REG_STAT 8'h05
`define CFGL_REG_OBS 8'h06
`define CFGL_REG_SEL 8'hFF
`define CFGL_STAT_DONE 4
`define CFGL_SEL_ALL 3
`define CFGL_SEL_CH 2
`define CFGL_OBS_KEY 4'hA
`define CFGL_SEL_RST 8'h00
`define CFGL_OBS_RST 4'h0
`define CFGL_ALL_SETS 4'hF
`define CFGL_ONE_SET 4'h1
`endif

// file: logic/cfgl_pkg.sv
// Types for the configuration loader and register paging block
package cfgl_pkg;
  typedef enum logic [3:0] {CFGL_LVL_LOW = 4'h1, CFGL_LVL_RES = 4'h2, CFGL_LVL_FLOAT = 4'h4,
    CFGL_LVL_HIGH = 4'h8} cfgl_level_type;
  typedef enum logic [3:0] {CFGL_MODE_SLAVE = 4'h1, CFGL_MODE_MASTER = 4'h2, CFGL_MODE_PIN = 4'h4,
    CFGL_MODE_NONE = 4'h8} cfgl_mode_type;
  typedef enum logic [4:0] {M_IDLE = 5'h01, M_START = 5'h02, M_BIT = 5'h04, M_STOP = 5'h08,
    M_DONE = 5'h10} cfgl_mst_type;
  typedef enum logic [4:0] {S_IDLE = 5'h01, S_ADDR = 5'h02, S_REG = 5'h04, S_DATA = 5'h08,
    S_READ = 5'h10} cfgl_slv_type;
  typedef struct packed {
    logic [3:0] mask;
    logic [7:0] addr;
    logic [7:0] data;
  } cfgl_ch_wr_type;
endpackage : cfgl_pkg

// file: logic/cfgl_lvl_decode.sv
// Four-level pin decoder
`timescale 1ns/1ps
module cfgl_lvl_decode
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Comparator code: 0 low, 1 resistor, 2 floating, 3 high
  input wire logic [1:0] code,
  output cfgl_pkg::cfgl_level_type level_q
);
  cfgl_pkg::cfgl_level_type level_d;

  always_comb
  begin
    unique case (code)
      2'h0: level_d = cfgl_pkg::CFGL_LVL_LOW;
      2'h1: level_d = cfgl_pkg::CFGL_LVL_RES;
      2'h2: level_d = cfgl_pkg::CFGL_LVL_FLOAT;
      2'h3: level_d = cfgl_pkg::CFGL_LVL_HIGH;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      level_q <= cfgl_pkg::CFGL_LVL_FLOAT;
    else
      level_q <= level_d;
  end
endmodule : cfgl_lvl_decode

// file: sim/cfgl_ee_model.sv
// Serial EEPROM model serving the configuration image
`timescale 1ns/1ps
module cfgl_ee_model
#(
  parameter logic [7:0] DEV = 8'hA0
)
(
  // Sampling clock
  input wire logic clk,
  // Resolved wires
  input wire logic scl,
  input wire logic sda,
  // Low pulls the data wire
  output logic pull_n
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [3:0] cnt;
  logic scl_p, sda_p, act, rd, first;
  initial
  begin
    {pull_n, scl_p, sda_p} = 3'h7;
    {act, rd, first, cnt, ptr} = '0;
  end
  // System clock sampling is far faster than the loader clock
  always @(posedge clk)
  begin
    scl_p <= scl;
    sda_p <= sda;
    if (scl && scl_p && sda_p && !sda)
    begin
      // Fall right after a start is not a bit
      {act, first, rd, cnt, pull_n} <= {3'h6, 4'hF, 1'b1};
    end
    else if (scl && scl_p && !sda_p && sda)
    begin
      {act, pull_n} <= 2'h1;
    end
    else if (act && scl && !scl_p)
    begin
      sh <= {sh[6:0], sda};
      if (cnt == 4'h8 && rd && sda)
        act <= 1'b0;
    end
    else if (act && !scl && scl_p)
    begin
      if (cnt == 4'h8)
      begin
        {cnt, first} <= 5'h0;
        pull_n <= rd ? mem[ptr][7] : 1'b1;
      end
      else if (cnt == 4'h7)
      begin
        cnt <= 4'h8;
        pull_n <= 1'b1;
        if (rd && !first)
          ptr <= ptr + 8'h01;
        else if (first && sh[7:1] != DEV[7:1])
          act <= 1'b0;
        else
        begin
          pull_n <= 1'b0;
          rd <= first & sh[0];
          if (!first)
            ptr <= sh;
        end
      end
      else
      begin
        cnt <= cnt + 4'h1;
        if (rd && !first)
          pull_n <= mem[ptr][4'h6 - cnt];
      end
    end
  end
endmodule : cfgl_ee_model

// file: sim/test_smbus_config_load_and_paging.sv
// Bench for the configuration loader and register paging block
`timescale 1ns/1ps
module test_smbus_config_load_and_paging;
  logic clk_sys, reset, load_req_n, h_scl, h_sda, ee_pull_n, scl_w, sda_w;
  logic done_n, scl_out, scl_oe_n, sda_out, sda_oe_n, pin_mode, mode_bad, wr_vld;
  logic [1:0] mode_pin, rd_sel, a0, a1, s;
  logic [3:0] adr_pin;
  logic [7:0] ctrl_pins, rd_addr, dev_w, r, a, d;
  cfgl_pkg::cfgl_level_type [3:0] levels;
  cfgl_pkg::cfgl_ch_wr_type wr;
  cfgl_pkg::cfgl_ch_wr_type wr_q[$];
  int error_cnt, checked, busy, n, seed;

  function automatic logic [7:0] ch_val(input logic [1:0] sel, input logic [7:0] ad);
    return ad ^ {sel, sel, 4'h5};
  endfunction : ch_val

  // Open-drain wires with pull-ups
  assign scl_w = h_scl & (scl_oe_n | scl_out);
  assign sda_w = h_sda & (sda_oe_n | sda_out) & ee_pull_n;

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  cfgl_top #(.NUM_CTRL(4), .LOAD_BYTES(4)) u_dut (.CLK_SYS(clk_sys), .RESET(reset),
    .MODE_STRAP_PIN(mode_pin), .ADDR_STRAP_PINS(adr_pin), .CTRL_PINS(ctrl_pins),
    .LOAD_REQUEST_N(load_req_n), .LOAD_DONE_N(done_n), .SMB_SCL_IN(scl_w), .SMB_SCL_OUT(scl_out),
    .SMB_SCL_OE_N(scl_oe_n), .SMB_SDA_IN(sda_w), .SMB_SDA_OUT(sda_out), .SMB_SDA_OE_N(sda_oe_n),
    .PIN_MODE(pin_mode), .MODE_INVALID(mode_bad), .CTRL_LEVELS(levels), .CH_WR_VALID(wr_vld),
    .CH_WR(wr), .CH_RD_SEL(rd_sel), .CH_RD_ADDR(rd_addr), .CH_RDATA(ch_val(rd_sel, rd_addr)));

  cfgl_ee_model u_ee (.clk(clk_sys), .scl(scl_w), .sda(sda_w), .pull_n(ee_pull_n));

  always @(posedge clk_sys)
    if (wr_vld === 1'b1)
      wr_q.push_back(wr);

  task automatic stop_test;
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_wr(input cfgl_pkg::cfgl_ch_wr_type e);
    cfgl_pkg::cfgl_ch_wr_type g;
    g = 'x;
    if (wr_q.size() > 0)
      g = wr_q.pop_front();
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH ch_wr expected %h seen %h", e, g);
    end
  endtask : chk_wr

  // Each step holds four cycles, so SCL is high four and low eight per bit; the slave has no timeout, so slower edge rates work too
  task automatic hw(input logic c, input logic dv);
    h_scl <= c;
    h_sda <= dv;
    repeat (4) @(posedge clk_sys);
  endtask : hw

  task automatic hbit(input logic b, output logic sv);
    hw(1'b0, b);
    hw(1'b1, b);
    sv = sda_w;
    hw(1'b0, b);
  endtask : hbit

  task automatic hbyte(input logic [7:0] w, input logic last, output logic [7:0] rv, output logic ack);
    logic sv;
    for (int i = 7; i >= 0; i--)
    begin
      hbit(w[i], sv);
      rv[i] = sv;
    end
    hbit(last, sv);
    ack = ~sv;
  endtask : hbyte

  task automatic hstart;
    hw(1'b0, 1'b1);
    hw(1'b1, 1'b1);
    hw(1'b1, 1'b0);
    hw(1'b0, 1'b0);
  endtask : hstart

  task automatic hstop;
    hw(1'b0, 1'b0);
    hw(1'b1, 1'b0);
    hw(1'b1, 1'b1);
  endtask : hstop

  task automatic reg_wr(input logic [7:0] ad, input logic [7:0] dv, input logic exp);
    logic [7:0] x;
    logic k0, k1, k2;
    hstart();
    hbyte(dev_w, 1'b1, x, k0);
    hbyte(ad, 1'b1, x, k1);
    hbyte(dv, 1'b1, x, k2);
    hstop();
    chk("wr_ack", {7'h0, exp}, {7'h0, k0 & k1 & k2});
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] ad, output logic [7:0] dv);
    logic [7:0] x;
    logic k0, k1, k2, k3;
    hstart();
    hbyte(dev_w, 1'b1, x, k0);
    hbyte(ad, 1'b1, x, k1);
    hstart();
    hbyte(dev_w | 8'h01, 1'b1, x, k2);
    hbyte(8'hFF, 1'b1, dv, k3);
    hstop();
    chk("rd_ack", 8'h07, {5'h0, k0, k1, k2});
  endtask : reg_rd

  task automatic do_reset(input logic [1:0] m, input logic [3:0] ad);
    reset <= 1'b1;
    mode_pin <= m;
    adr_pin <= ad;
    repeat (5) @(posedge clk_sys);
    chk("rst_out", 8'h03, {6'h0, done_n, scl_oe_n & sda_oe_n});
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : do_reset

  task automatic quiet(input int cyc);
    busy = 0;
    repeat (cyc)
    begin
      @(posedge clk_sys);
      if (scl_oe_n !== 1'b1 || sda_oe_n !== 1'b1)
        busy++;
    end
  endtask : quiet

  initial
  begin
    repeat (90000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end

  initial
  begin
    {reset, h_scl, h_sda, load_req_n, mode_pin, adr_pin, ctrl_pins} = {3'h7, 1'b0, 2'h3, 12'h0};
    {error_cnt, checked} = '0;
    seed = $urandom(32'hE202);
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++)
    begin
      // Zero straps as low, resistor or floating
      a0 = i[0] ? 2'h3 : 2'($urandom % 3);
      a1 = i[1] ? 2'h3 : 2'($urandom % 3);
      do_reset(2'h3, {a1, a0});
      chk("mode", 8'h00, {6'h0, pin_mode, mode_bad});
      adr_pin <= 4'($urandom);
      dev_w = 8'h30 + 8'(2 * ((i + 1) % 4));
      reg_wr(8'h06, 8'h0A, 1'b0);
      dev_w = 8'h30 + 8'(2 * i);
      reg_wr(8'h06, 8'h0A, 1'b1);
      reg_rd(8'h00, r);
      chk("strap", 8'(i << 4), r);
      reg_rd(8'h05, r);
      chk("stat", 8'h00, r);
      reg_rd(8'hFF, r);
      reg_wr(8'hFF, (r & 8'hF8) | 8'h04 | 8'(i), 1'b1);
      a = 8'($urandom % 255);
      d = 8'($urandom);
      reg_wr(a, d, 1'b1);
      chk_wr({4'h1 << i, a, d});
      reg_rd(a, r);
      chk("ch_rd", ch_val(2'(i), a), r);
      reg_wr(8'hFF, 8'h0C | 8'(i), 1'b1);
      reg_rd(8'hFF, r);
      chk("sel", 8'h0C | 8'(i), r);
      reg_wr(a, d, 1'b1);
      chk_wr({4'hF, a, d});
      reg_wr(8'hFF, 8'h08, 1'b1);
      reg_wr(8'h06, d, 1'b1);
      reg_rd(8'h06, r);
      chk("shared", {4'h0, d[3:0]}, r);
      chk("wr_left", 8'h00, 8'(wr_q.size()));
    end
    do_reset(2'h0, 4'h0);
    chk("mode", 8'h02, {6'h0, pin_mode, mode_bad});
    for (int j = 0; j < 3; j++)
    begin
      ctrl_pins <= (j == 0) ? 8'hE4 : 8'($urandom);
      repeat (3) @(posedge clk_sys);
      for (int k = 0; k < 4; k++)
        chk("level", 8'(4'h1 << ctrl_pins[2*k +: 2]), {4'h0, levels[k]});
    end
    do_reset(2'h1, 4'h0);
    chk("mode", 8'h01, {6'h0, pin_mode, mode_bad});
    s = 2'($urandom);
    a = 8'($urandom % 255);
    d = 8'($urandom);
    {u_ee.mem[0], u_ee.mem[1], u_ee.mem[2], u_ee.mem[3]} = {8'hFF, 8'h04 | 8'(s), a, d};
    load_req_n <= 1'b1;
    do_reset(2'h2, 4'h0);
    quiet(300);
    chk("early_drive", 8'h00, 8'(busy));
    chk("early_done", 8'h01, {7'h0, done_n});
    load_req_n <= 1'b0;
    n = 0;
    while (done_n !== 1'b0 && n < 8000)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("done", 8'h00, {7'h0, done_n});
    chk_wr({4'h1 << s, a, d});
    load_req_n <= 1'b1;
    quiet(300);
    chk("late_drive", 8'h00, 8'(busy));
    chk("done_hold", 8'h00, {7'h0, done_n});
    dev_w = 8'h30;
    reg_rd(8'hFF, r);
    chk("sel_load", 8'h04 | 8'(s), r);
    reg_wr(8'hFF, 8'h00, 1'b1);
    reg_rd(8'h05, r);
    chk("stat", 8'h10, r);
    stop_test();
  end
endmodule : test_smbus_config_load_and_paging
